// >>> pkg/alarm_lines_pkg.sv
// Package with register map, field layouts and reset values for the alarm output lines.
// Operation
// [RULE1] In hold mode a line goes to its active level on the first alarm of any assigned channel.
// [RULE2] In hold mode a line stays active until a clear, a new scan or a reset, whatever follows.
// [RULE3] In follow mode a line is active while an assigned channel reading lies beyond a limit.
// [RULE4] In follow mode a line returns to inactive once the reading is back inside the limits.
// [RULE5] A clear is taken at any time, deasserts the line and keeps the stored alarm data.
// [RULE6] Starting a new scan deasserts every line and discards the stored alarm data.
// [RULE7] There is a per-line clear by index and a clear-all that deasserts all four lines.
// [RULE8] A factory reset deasserts all lines and leaves the queued alarm records untouched.
// [RULE9] A factory reset puts every line into hold mode, which is also the default.
// [RULE10] A mode write without a line index applies the mode to all four lines at once.
// [RULE11] For a selected line the block reports the assigned channels with alarms enabled.
// [RULE12] Each line has a polarity, active low by default, active high when selected.
// [RULE13] Each channel maps to exactly one alarm line.
// [RULE14] Per channel an out-of-limit level and a new-reading strobe are evaluated on the clock.
package alarm_lines_pkg;
    localparam int         NUM_LINES  = 4;
    localparam int         NUM_CHAN   = 16;
    localparam int         LINE_W     = 2;
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_MODE  = 8'h04;
    localparam logic [7:0] ADDR_POL   = 8'h08;
    localparam logic [7:0] ADDR_ENA   = 8'h0c;
    localparam logic [7:0] ADDR_MAP   = 8'h10;
    localparam logic [7:0] ADDR_SEL   = 8'h14;
    localparam logic [7:0] ADDR_RPT   = 8'h18;
    localparam logic [7:0] ADDR_LINES = 8'h1c;
    localparam logic [7:0] ADDR_DATA  = 8'h20;
    localparam logic [7:0] ADDR_STAT  = 8'h24;
    localparam logic [7:0] ADDR_MASK  = 8'h28;
    localparam int         CTRL_CLR_LO  = 0;
    localparam int         CTRL_CLR_HI  = 1;
    localparam int         CTRL_CLR_GO  = 2;
    localparam int         CTRL_CLR_ALL = 3;
    localparam int         CTRL_SCAN    = 4;
    localparam int         CTRL_FRST    = 5;
    localparam int         MODE_ALL     = 8;
    localparam int         MODE_ALLVAL  = 9;
    localparam logic [3:0] MODE_RST     = 4'h0;
    localparam logic [3:0] POL_RST      = 4'h0;
    localparam logic [15:0] ENA_RST     = 16'h0000;
    localparam logic [31:0] MAP_RST     = 32'h0000_0000;
    localparam logic [31:0] BUS_ZERO    = 32'h0000_0000;
endpackage

// >>> core/alarm_output_lines.sv
// Alarm output line controller with a classic Wishbone register slave.
//
// Chosen here: the address map and the Wishbone register port.
module alarm_output_lines #(
    parameter int NUM_CHAN = alarm_lines_pkg::NUM_CHAN
) (
    input  wire logic                i_clk,          // System clock, 10 MHz.
    input  wire logic                i_sys_rst,      // Synchronous reset, active high.
    input  wire logic [NUM_CHAN-1:0] i_out_of_limit, // Per channel reading beyond a limit.
    input  wire logic [NUM_CHAN-1:0] i_new_reading,  // Per channel new reading strobe.
    input  wire logic                i_scan_start,   // New scan begins, one-cycle pulse.
    input  wire logic                i_wb_cyc,       // Wishbone cycle.
    input  wire logic                i_wb_stb,       // Wishbone strobe.
    input  wire logic                i_wb_we,        // Wishbone write enable.
    input  wire logic [7:0]          i_wb_adr,       // Wishbone byte address.
    input  wire logic [3:0]          i_wb_sel,       // Wishbone byte selects.
    input  wire logic [31:0]         i_wb_dat,       // Wishbone write data.
    output logic      [31:0]         o_wb_dat,       // Wishbone read data.
    output logic                     o_wb_ack,       // Wishbone acknowledge.
    output logic      [3:0]          o_alarm_pin,    // Alarm output pins.
    output logic                     o_irq           // Level interrupt.
);
    localparam int NL = alarm_lines_pkg::NUM_LINES;
    localparam int LW = alarm_lines_pkg::LINE_W;

    typedef enum logic {HOLD_MODE, FOLLOW_MODE} line_mode_t;

    logic [NL-1:0]         mode_reg;      // One bit per line: 1 is follow mode.
    logic [NL-1:0]         pol_reg;       // One bit per line: 1 is active_high_polarity.
    logic [NUM_CHAN-1:0]   ena_reg;
    logic [2*NUM_CHAN-1:0] map_reg;
    logic [LW-1:0]         sel_reg;
    logic [NL-1:0]         hold_reg;
    logic [NL-1:0]         follow_reg;
    logic [NUM_CHAN-1:0]   data_reg;      // Stored alarm data per channel.
    logic [NL-1:0]         stat_reg;
    logic [NL-1:0]         mask_reg;
    logic [NL-1:0]         active;
    logic [NL-1:0]         hit;
    logic [NL-1:0]         beyond;
    logic [NL-1:0]         clr_line;
    logic [NUM_CHAN-1:0]   rpt;
    logic [31:0]           rd_next;
    logic                  req;
    logic                  wr;
    logic                  frst;

    assign req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr   = req && i_wb_we && i_wb_sel[0];
    assign frst = wr && i_wb_adr == alarm_lines_pkg::ADDR_CTRL
                  && i_wb_dat[alarm_lines_pkg::CTRL_FRST];

    // A channel's two-bit map field names one line, so no channel can feed two lines.
    always_comb begin
        hit    = '0;
        beyond = '0;
        rpt    = '0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (ena_reg[c]) begin
                if (i_new_reading[c] && i_out_of_limit[c]) begin
                    hit[map_reg[2*c +: 2]] = 1'b1; // [RULE13] [RULE14]
                end
                if (i_out_of_limit[c]) begin
                    beyond[map_reg[2*c +: 2]] = 1'b1; // [RULE3] [RULE14]
                end
                if (map_reg[2*c +: 2] == sel_reg) begin
                    rpt[c] = 1'b1; // [RULE11]
                end
            end
        end
    end

    always_comb begin
        clr_line = '0;
        if (wr && i_wb_adr == alarm_lines_pkg::ADDR_CTRL) begin
            if (i_wb_dat[alarm_lines_pkg::CTRL_CLR_ALL]) begin
                clr_line = '1; // [RULE7]
            end else if (i_wb_dat[alarm_lines_pkg::CTRL_CLR_GO]) begin
                clr_line[i_wb_dat[alarm_lines_pkg::CTRL_CLR_HI:
                                  alarm_lines_pkg::CTRL_CLR_LO]] = 1'b1; // [RULE7]
            end
        end
    end

    // Configuration registers. Factory reset is a control bit and also the reset pin.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frst) begin
            mode_reg <= alarm_lines_pkg::MODE_RST; // [RULE9]
            pol_reg  <= alarm_lines_pkg::POL_RST;  // [RULE12]
            ena_reg  <= alarm_lines_pkg::ENA_RST;
            map_reg  <= alarm_lines_pkg::MAP_RST;
            sel_reg  <= '0;
            mask_reg <= '0;
        end else if (wr) begin
            unique case (i_wb_adr)
                alarm_lines_pkg::ADDR_MODE: begin
                    if (i_wb_dat[alarm_lines_pkg::MODE_ALL]) begin
                        mode_reg <= {NL{i_wb_dat[alarm_lines_pkg::MODE_ALLVAL]}}; // [RULE10]
                    end else begin
                        mode_reg <= i_wb_dat[NL-1:0];
                    end
                end
                alarm_lines_pkg::ADDR_POL:  pol_reg  <= i_wb_dat[NL-1:0];
                alarm_lines_pkg::ADDR_ENA:  ena_reg  <= i_wb_dat[NUM_CHAN-1:0];
                alarm_lines_pkg::ADDR_MAP:  map_reg  <= i_wb_dat[2*NUM_CHAN-1:0];
                alarm_lines_pkg::ADDR_SEL:  sel_reg  <= i_wb_dat[LW-1:0];
                alarm_lines_pkg::ADDR_MASK: mask_reg <= i_wb_dat[NL-1:0];
                default: ;
            endcase
        end
    end

    // Hold latches. A clear in the same cycle as a new alarm lets the alarm win.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frst) begin
            hold_reg <= '0; // [RULE8]
        end else if (i_scan_start) begin
            hold_reg <= '0; // [RULE6]
        end else begin
            hold_reg <= (hold_reg & ~clr_line) | hit; // [RULE1] [RULE2] [RULE5]
        end
    end

    // Follow state: a clear drops the line until the next out-of-limit reading.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frst || i_scan_start) begin
            follow_reg <= '0; // [RULE6] [RULE8]
        end else begin
            follow_reg <= ((follow_reg & ~clr_line) | hit) & beyond; // [RULE3] [RULE4] [RULE5]
        end
    end

    // Alarm data survives clears and factory reset; only a scan start discards it.
    always_ff @(posedge i_clk) begin
        if (i_scan_start) begin
            data_reg <= '0; // [RULE6]
        end else begin
            data_reg <= data_reg | (i_new_reading & i_out_of_limit & ena_reg); // [RULE5] [RULE8]
        end
    end

    always_comb begin
        for (int l = 0; l < NL; l++) begin
            active[l] = (line_mode_t'(mode_reg[l]) == FOLLOW_MODE) ? follow_reg[l] : hold_reg[l];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_alarm_pin <= ~alarm_lines_pkg::POL_RST;
        end else begin
            o_alarm_pin <= ~(active ^ pol_reg); // [RULE12]
        end
    end

    always_comb begin
        rd_next = alarm_lines_pkg::BUS_ZERO;
        unique case (i_wb_adr)
            alarm_lines_pkg::ADDR_MODE:  rd_next[NL-1:0]         = mode_reg;
            alarm_lines_pkg::ADDR_POL:   rd_next[NL-1:0]         = pol_reg;
            alarm_lines_pkg::ADDR_ENA:   rd_next[NUM_CHAN-1:0]   = ena_reg;
            alarm_lines_pkg::ADDR_MAP:   rd_next[2*NUM_CHAN-1:0] = map_reg;
            alarm_lines_pkg::ADDR_SEL:   rd_next[LW-1:0]         = sel_reg;
            alarm_lines_pkg::ADDR_RPT:   rd_next[NUM_CHAN-1:0]   = rpt; // [RULE11]
            alarm_lines_pkg::ADDR_LINES: rd_next[NL-1:0]         = active;
            alarm_lines_pkg::ADDR_DATA:  rd_next[NUM_CHAN-1:0]   = data_reg;
            alarm_lines_pkg::ADDR_STAT:  rd_next[NL-1:0]         = stat_reg;
            alarm_lines_pkg::ADDR_MASK:  rd_next[NL-1:0]         = mask_reg;
            default: ;
        endcase
    end

    // Every access is acknowledged one cycle after it appears; unmapped reads give zero.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= alarm_lines_pkg::BUS_ZERO;
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= (req && !i_wb_we) ? rd_next : alarm_lines_pkg::BUS_ZERO;
        end
    end

    // Sticky line-alarm events; a read of the status register clears them, new events win.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            stat_reg <= '0;
        end else if (req && !i_wb_we && i_wb_adr == alarm_lines_pkg::ADDR_STAT) begin
            stat_reg <= hit;
        end else begin
            stat_reg <= stat_reg | hit;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat_reg & mask_reg);
        end
    end
endmodule

// >>> tb/alarm_output_lines_props.sv
// Port-level checks for the alarm output line controller.
module alarm_output_lines_props #(
    parameter int NUM_CHAN = 16
) (
    input wire logic                i_clk,          // Clock.
    input wire logic                i_sys_rst,      // Reset.
    input wire logic [NUM_CHAN-1:0] i_out_of_limit, // Limit levels.
    input wire logic [NUM_CHAN-1:0] i_new_reading,  // Reading strobes.
    input wire logic                i_scan_start,   // Scan pulse.
    input wire logic                i_wb_cyc,       // Bus cycle.
    input wire logic                i_wb_stb,       // Bus strobe.
    input wire logic                i_wb_we,        // Bus write.
    input wire logic [7:0]          i_wb_adr,       // Bus address.
    input wire logic [3:0]          i_wb_sel,       // Bus selects.
    input wire logic [31:0]         i_wb_dat,       // Bus write data.
    input wire logic [31:0]         o_wb_dat,       // Bus read data.
    input wire logic                o_wb_ack,       // Bus acknowledge.
    input wire logic [3:0]          o_alarm_pin,    // Alarm pins.
    input wire logic                o_irq           // Interrupt.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       req;
    logic [3:0] pol_reg;
    logic       far_rd_reg;
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    // Polarity is shadowed so that the inactive level of each pin is known.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pol_reg <= 4'h0;
        end else if (req && i_wb_we && i_wb_sel[0] && i_wb_adr == alarm_lines_pkg::ADDR_POL) begin
            pol_reg <= i_wb_dat[3:0];
        end else if (req && i_wb_we && i_wb_sel[0] && i_wb_adr == 8'h00 && i_wb_dat[5]) begin
            pol_reg <= 4'h0;
        end
    end
    always_ff @(posedge i_clk) begin
        far_rd_reg <= req && !i_wb_we && i_wb_adr > 8'h28;
    end
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ack_answer_a: assert property (req |=> o_wb_ack) else $error("no ack");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
    ack_cause_a: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("stray ack");
    idle_data_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data");
    unmapped_read_a: assert property (o_wb_ack && far_rd_reg |-> o_wb_dat == 32'h0)
        else $error("unmapped data");
    reset_pins_a: assert property ($fell(i_sys_rst) |-> o_alarm_pin == 4'hf && !o_irq)
        else $error("reset pins");
    scan_clear_a: assert property (i_scan_start |=> ##1 o_alarm_pin == ~pol_reg)
        else $error("scan clear");
    quiet_pins_a: assert property ((!i_wb_cyc && !i_scan_start && i_new_reading == '0
        && $stable(i_out_of_limit)) [*3] |-> $stable(o_alarm_pin)) else $error("pin moved");
endmodule
bind alarm_output_lines alarm_output_lines_props #(.NUM_CHAN(NUM_CHAN)) i_props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_out_of_limit(i_out_of_limit),
    .i_new_reading(i_new_reading), .i_scan_start(i_scan_start), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_alarm_pin(o_alarm_pin), .o_irq(o_irq));

// >>> tb/alarm_pin_monitor.sv
// Equipment watching the alarm pins, decoding them with its configured polarity.
module alarm_pin_monitor (
    input  wire logic [3:0] i_pin,    // Pins as seen on the cable.
    input  wire logic [3:0] i_pol,    // Polarity the equipment expects.
    output logic      [3:0] o_active  // Decoded alarm per line.
);
    timeunit 1ns;
    timeprecision 1ns;
    assign o_active = i_pin ^ ~i_pol;
endmodule

// >>> tb/alarm_output_lines_bench.sv
// Self-checking bench for the alarm output line controller.
module alarm_output_lines_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 0, i_sys_rst = 1, scan = 0, cyc = 0, stb = 0, we = 0, o_wb_ack, o_irq;
    logic [15:0] oor = '0, nr = '0, r16;
    logic [7:0]  adr = '0;
    logic [3:0]  sel = 4'hf, pol_v = 4'h0, o_alarm_pin, act;
    logic [31:0] wdat = '0, rd, d0, o_wb_dat;
    int          failures = 0, compares = 0, c, l;
    alarm_output_lines i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_out_of_limit(oor),
        .i_new_reading(nr), .i_scan_start(scan), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .o_alarm_pin(o_alarm_pin), .o_irq(o_irq));
    alarm_pin_monitor i_mon (.i_pin(o_alarm_pin), .i_pol(pol_v), .o_active(act));
    initial forever #50 i_clk = ~i_clk;
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin @(posedge i_clk); n++; end while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1) begin failures++; print_verdict(); end
        rd = o_wb_dat;
        cyc <= 0; stb <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(0, a, 32'h0);
        chk("register", rd, exp);
    endtask
    task automatic hit(input int ch, input logic keep);
        @(posedge i_clk); nr <= 16'h1 << ch; oor <= oor | (16'h1 << ch);
        @(posedge i_clk); nr <= '0; if (!keep) oor <= '0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic pulse_scan();
        @(posedge i_clk); scan <= 1;
        @(posedge i_clk); scan <= 0;
        repeat (3) @(posedge i_clk);
    endtask
    initial begin
        void'($urandom(32'h36a1));
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 0;
        pulse_scan();
        chk("pins", o_alarm_pin, 4'hf);
        rdchk(alarm_lines_pkg::ADDR_MODE, 32'h0);
        rdchk(alarm_lines_pkg::ADDR_POL, 32'h0);
        rdchk(8'h30, 32'h0);
        $display("test reset done");
        r16 = 16'($urandom);
        wb(1, alarm_lines_pkg::ADDR_MAP, 32'he4e4e4e4);
        wb(1, alarm_lines_pkg::ADDR_ENA, {16'h0, r16});
        for (l = 0; l < 4; l++) begin
            wb(1, alarm_lines_pkg::ADDR_SEL, 32'(l));
            rdchk(alarm_lines_pkg::ADDR_RPT, {16'h0, r16 & (16'h1111 << l)});
        end
        wb(1, alarm_lines_pkg::ADDR_ENA, 32'hffff);
        c = $urandom_range(15);
        l = c % 4;
        hit(c, 0);
        repeat (5) @(posedge i_clk);
        chk("active", act, 4'h1 << l);
        rdchk(alarm_lines_pkg::ADDR_LINES, 32'h1 << l);
        wb(0, alarm_lines_pkg::ADDR_DATA, 32'h0);
        d0 = rd;
        wb(1, 8'h00, 32'h4 | 32'(l));
        repeat (3) @(posedge i_clk);
        chk("active", act, 4'h0);
        rdchk(alarm_lines_pkg::ADDR_DATA, d0);
        hit(0, 0);
        hit(3, 0);
        chk("active", act, 4'h9);
        wb(1, 8'h00, 32'h8);
        repeat (3) @(posedge i_clk);
        chk("active", act, 4'h0);
        $display("test hold done");
        wb(1, alarm_lines_pkg::ADDR_MASK, 32'h0);
        hit(c, 0);
        chk("irq", o_irq, 1'b0);
        // Status is sticky, so the earlier hits on lines 0 and 3 are still recorded.
        rdchk(alarm_lines_pkg::ADDR_STAT, 32'h9 | (32'h1 << l));
        wb(1, alarm_lines_pkg::ADDR_MASK, 32'hf);
        hit(c, 0);
        chk("irq", o_irq, 1'b1);
        rdchk(alarm_lines_pkg::ADDR_STAT, 32'h1 << l);
        repeat (2) @(posedge i_clk);
        chk("irq", o_irq, 1'b0);
        pulse_scan();
        chk("active", act, 4'h0);
        rdchk(alarm_lines_pkg::ADDR_DATA, 32'h0);
        $display("test scan done");
        wb(1, alarm_lines_pkg::ADDR_MODE, 32'h300);
        chk("mode", rd[3:0], 4'h0);
        wb(0, alarm_lines_pkg::ADDR_MODE, 32'h0);
        chk("mode", rd[3:0], 4'hf);
        wb(1, alarm_lines_pkg::ADDR_POL, 32'hf);
        pol_v = 4'hf;
        hit(c, 1);
        chk("active", act, 4'h1 << l);
        chk("pins", o_alarm_pin, 4'h1 << l);
        @(posedge i_clk); oor <= '0;
        repeat (3) @(posedge i_clk);
        chk("active", act, 4'h0);
        $display("test follow done");
        hit(c, 0);
        wb(0, alarm_lines_pkg::ADDR_DATA, 32'h0);
        d0 = rd;
        wb(1, 8'h00, 32'h20);
        pol_v = 4'h0;
        repeat (3) @(posedge i_clk);
        chk("pins", o_alarm_pin, 4'hf);
        rdchk(alarm_lines_pkg::ADDR_MODE, 32'h0);
        rdchk(alarm_lines_pkg::ADDR_DATA, d0);
        $display("test factory done");
        print_verdict();
    end
endmodule
